// ==== design/hcur_regs.sv ====
// hcur_regs.sv: cursor colour 1 and AND mask address registers with pixel fetch
// assumes: indexed data port already decoded to a write/read strobe with index;
// display pipe supplies cursor row/column and plane bytes it fetched.
// the colour and address registers carry no reset, so software must program
// them before the cursor is shown; fetch address and class lag row/column by one clock.
//
// How it works
// RL1: red component of colour 1 held in eight read/write bits.
// RL2: green component of colour 1 held in its own eight-bit register.
// RL3: blue component of colour 1 held in its own eight-bit register.
// RL4: colour 1 and low address registers are not reset.
// RL5: low address bits 7..1 give AND mask address bits 15..9.
// RL6: XOR mask starts 512 bytes above the AND mask base.
// RL7: software keeps the bitmap on a 1 KByte boundary.
// RL8: top-left pixel uses bit 7 of first AND and XOR bytes.
// RL9: next pixel uses next lower bit, then the next byte.
// RL10: software writes zero to reserved bit 0 of low address.
// RL11: registers reached through indexed data port at indices 2d to 32.
// RL12: cursor width fixed at 64 pixels, no width register.
// RL13: middle address register gives AND mask bits 23..16.
// RL14: high address register gives bits 26..24; upper bits reserved.
// RL15: AND/XOR pairs pick colour 0, colour 1, screen, or invert.
`timescale 1ns/1ps
`default_nettype none
`include "hcur_defs.svh"

module hcur_regs
    import hcur_pkg::*;
(
    input  wire logic        mclk,
    input  wire logic        rst,
    input  wire hcur_port_t  port,
    input  wire logic [5:0]  pix_row,
    input  wire logic [5:0]  pix_col,
    input  wire logic [7:0]  and_byte,
    input  wire logic [7:0]  xor_byte,
    output logic      [7:0]  rdata,
    output logic             rvalid,
    output hcur_rgb_t        color1,
    output logic      [26:0] and_base,
    output logic      [26:0] fetch_and_addr,
    output logic      [26:0] fetch_xor_addr,
    output hcur_pix_t        pix_kind
);
    hcur_rgb_t   color1_q,   color1_d;
    logic [7:1]  addr_low_q, addr_low_d;
    logic [7:0]  addr_mid_q, addr_mid_d;
    logic [2:0]  addr_hi_q,  addr_hi_d;
    logic [7:0]  rdata_q,    rdata_d;
    logic        rvalid_q,   rvalid_d;
    logic [26:0] fa_q, fa_d, fx_q, fx_d;
    hcur_pix_t   kind_q, kind_d;
    logic [26:0] base_w, and_a, xor_a;
    logic [2:0]  bsel;
    // assertion helper: one bit per address register written since reset
    logic [2:0]  addr_seen_q, addr_seen_d;

    // one index comparator shared by the write decode and the seen flags
    function automatic logic hit(input logic [7:0] idx, input logic [7:0] want);
        hit = (idx == want);
    endfunction : hit

    // RL5 RL13 RL14 linear address assembly, RL7 low bits zero
    // bit 9 stays programmable: keeping it clear for 1 KByte alignment is up to software
    assign base_w = {addr_hi_q, addr_mid_q, addr_low_q, 9'h000};

    hcur_bitmap_addr hcur_bitmap_addr_inst (
        .base     (base_w),
        .row      (pix_row),
        .col      (pix_col),
        .and_addr (and_a),
        .xor_addr (xor_a),
        .bit_sel  (bsel)
    );

    // config state: no reset on purpose, values undefined until written
    always_comb begin
        color1_d   = color1_q;
        addr_low_d = addr_low_q;
        addr_mid_d = addr_mid_q;
        addr_hi_d  = addr_hi_q;
        // RL11 indexed register writes
        if (port.wr) begin
            // RL1 red
            if (hit(port.index, `HCUR_IDX_RED))      color1_d.red   = port.wdata;
            // RL2 green
            if (hit(port.index, `HCUR_IDX_GREEN))    color1_d.green = port.wdata;
            // RL3 blue
            if (hit(port.index, `HCUR_IDX_BLUE))     color1_d.blue  = port.wdata;
            // reserved bits are not stored, so a stray one cannot reach the base
            // RL5 RL10 bit 0 dropped
            if (hit(port.index, `HCUR_IDX_ADDR_LOW)) addr_low_d = port.wdata[7:1];
            // RL13 middle bits
            if (hit(port.index, `HCUR_IDX_ADDR_MID)) addr_mid_d = port.wdata;
            // RL14 upper bits reserved
            if (hit(port.index, `HCUR_IDX_ADDR_HIGH)) addr_hi_d = port.wdata[2:0];
        end
    end

    // RL4 no reset applied
    always_ff @(posedge mclk) begin
        color1_q   <= color1_d;
        addr_low_q <= addr_low_d;
        addr_mid_q <= addr_mid_d;
        addr_hi_q  <= addr_hi_d;
    end

    // the mask base is undefined until all three address registers are written;
    // fetch checks wait on these bits instead of looking at unknown values.
    // a mid-run reset clears them although the registers keep their contents,
    // which only quiets those checks until software writes the base again
    always_comb begin
        addr_seen_d = addr_seen_q;
        if (port.wr) begin
            if (hit(port.index, `HCUR_IDX_ADDR_LOW))  addr_seen_d[0] = 1'b1;
            if (hit(port.index, `HCUR_IDX_ADDR_MID))  addr_seen_d[1] = 1'b1;
            if (hit(port.index, `HCUR_IDX_ADDR_HIGH)) addr_seen_d[2] = 1'b1;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            addr_seen_q <= 3'h0;
        end else begin
            addr_seen_q <= addr_seen_d;
        end
    end

    // rdata is held between reads so the port can take it a cycle late
    always_comb begin
        rdata_d  = rdata_q;
        rvalid_d = port.rd;
        // RL11 indexed register reads
        if (port.rd) begin
            case (port.index)
                `HCUR_IDX_RED:       rdata_d = color1_q.red;
                `HCUR_IDX_GREEN:     rdata_d = color1_q.green;
                `HCUR_IDX_BLUE:      rdata_d = color1_q.blue;
                // reserved bit reads as zero
                `HCUR_IDX_ADDR_LOW:  rdata_d = {addr_low_q, 1'b0};
                `HCUR_IDX_ADDR_MID:  rdata_d = addr_mid_q;
                `HCUR_IDX_ADDR_HIGH: rdata_d = {5'h00, addr_hi_q};
                default:             rdata_d = 8'h00;
            endcase
        end
    end

    // addresses and class are registered together so the pipe sees them on one edge
    // RL12 width fixed: column is 6 bits, 64 pixels
    // RL15 pixel classification from the two plane bits
    always_comb begin
        fa_d = and_a;
        fx_d = xor_a;
        case ({and_byte[bsel], xor_byte[bsel]})
            2'b00:   kind_d = HCUR_PIX_COLOR0;
            2'b01:   kind_d = HCUR_PIX_COLOR1;
            2'b10:   kind_d = HCUR_PIX_SCREEN;
            2'b11:   kind_d = HCUR_PIX_INVERT;
            default: kind_d = HCUR_PIX_SCREEN;
        endcase
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            rdata_q  <= 8'h00;
            rvalid_q <= 1'b0;
            fa_q     <= 27'h0000000;
            fx_q     <= 27'h0000000;
            kind_q   <= HCUR_PIX_SCREEN;
        end else begin
            rdata_q  <= rdata_d;
            rvalid_q <= rvalid_d;
            fa_q     <= fa_d;
            fx_q     <= fx_d;
            kind_q   <= kind_d;
        end
    end

    assign rdata          = rdata_q;
    assign rvalid         = rvalid_q;
    assign color1         = color1_q;
    assign and_base       = base_w;
    assign fetch_and_addr = fa_q;
    assign fetch_xor_addr = fx_q;
    assign pix_kind       = kind_q;

    // register write paths
    a_red_write: assert property (@(posedge mclk) disable iff (rst) // RL1
        port.wr && port.index == `HCUR_IDX_RED |=> color1.red == $past(port.wdata))
        else $error("red not stored");
    a_green_write: assert property (@(posedge mclk) disable iff (rst) // RL2
        port.wr && port.index == `HCUR_IDX_GREEN |=> color1.green == $past(port.wdata))
        else $error("green not stored");
    a_blue_write: assert property (@(posedge mclk) disable iff (rst) // RL3
        port.wr && port.index == `HCUR_IDX_BLUE |=> color1.blue == $past(port.wdata))
        else $error("blue not stored");
    a_low_addr: assert property (@(posedge mclk) disable iff (rst) // RL5
        port.wr && port.index == `HCUR_IDX_ADDR_LOW
        |=> and_base[15:9] == $past(port.wdata[7:1]) && and_base[8:0] == 9'h000)
        else $error("low address field wrong");
    a_mid_addr: assert property (@(posedge mclk) disable iff (rst) // RL13
        port.wr && port.index == `HCUR_IDX_ADDR_MID |=> and_base[23:16] == $past(port.wdata))
        else $error("mid address field wrong");
    a_high_addr: assert property (@(posedge mclk) disable iff (rst) // RL14
        port.wr && port.index == `HCUR_IDX_ADDR_HIGH |=> and_base[26:24] == $past(port.wdata[2:0]))
        else $error("high address field wrong");

    // fetch address checks, quiet until the base is fully written;
    // the two planes are checked against each other and against the base
    a_xor_offset: assert property (@(posedge mclk) disable iff (rst) // RL6
        &addr_seen_q |=> fetch_xor_addr == fetch_and_addr + `HCUR_XOR_OFS)
        else $error("xor plane not 512 above");
    a_first_pixel: assert property (@(posedge mclk) disable iff (rst) // RL8
        &addr_seen_q && pix_row == 6'h00 && pix_col == 6'h00
        |=> fetch_and_addr == $past(base_w)
        && fetch_xor_addr == $past(base_w) + `HCUR_XOR_OFS)
        else $error("first pixel not at base");
    a_last_pixel: assert property (@(posedge mclk) disable iff (rst) // RL9
        &addr_seen_q && pix_row == 6'h3f && pix_col == 6'h3f
        |=> fetch_and_addr == $past(base_w) + {18'h00000, `HCUR_PLANE_LAST}
        && fetch_xor_addr == $past(base_w) + `HCUR_XOR_OFS + {18'h00000, `HCUR_PLANE_LAST})
        else $error("last pixel not at base plus 511");
    a_pixel_kind: assert property (@(posedge mclk) disable iff (rst) // RL15
        and_byte[3'h7 - pix_col[2:0]] && !xor_byte[3'h7 - pix_col[2:0]]
        |=> pix_kind == HCUR_PIX_SCREEN)
        else $error("transparent pixel misclassified");
    a_read_back: assert property (@(posedge mclk) disable iff (rst) // RL11
        port.rd && port.index == `HCUR_IDX_ADDR_LOW && !port.wr
        |=> rvalid && rdata == {and_base[15:9], 1'b0})
        else $error("low address readback wrong");

    // remaining readback paths; a write in the same cycle is excluded because
    // the read returns the value held before that edge
    a_read_red: assert property (@(posedge mclk) disable iff (rst) // RL1
        port.rd && !port.wr && port.index == `HCUR_IDX_RED
        |=> rvalid && rdata == color1.red)
        else $error("red readback wrong");
    a_read_green: assert property (@(posedge mclk) disable iff (rst) // RL2
        port.rd && !port.wr && port.index == `HCUR_IDX_GREEN
        |=> rvalid && rdata == color1.green)
        else $error("green readback wrong");
    a_read_blue: assert property (@(posedge mclk) disable iff (rst) // RL3
        port.rd && !port.wr && port.index == `HCUR_IDX_BLUE
        |=> rvalid && rdata == color1.blue)
        else $error("blue readback wrong");
    a_read_mid: assert property (@(posedge mclk) disable iff (rst) // RL13
        port.rd && !port.wr && port.index == `HCUR_IDX_ADDR_MID
        |=> rvalid && rdata == and_base[23:16])
        else $error("mid address readback wrong");
    a_read_high: assert property (@(posedge mclk) disable iff (rst) // RL14
        port.rd && !port.wr && port.index == `HCUR_IDX_ADDR_HIGH
        |=> rvalid && rdata == {5'h00, and_base[26:24]})
        else $error("high address readback wrong");

    a_unmapped_read: assert property (@(posedge mclk) disable iff (rst) // RL11
        port.rd && (port.index < `HCUR_IDX_RED || port.index > `HCUR_IDX_ADDR_HIGH)
        |=> rvalid && rdata == 8'h00)
        else $error("unmapped index did not read zero");
    a_rvalid_read: assert property (@(posedge mclk) disable iff (rst) // RL11
        port.rd |=> rvalid)
        else $error("read not acknowledged");
    a_rvalid_idle: assert property (@(posedge mclk) disable iff (rst) // RL11
        !port.rd |=> !rvalid && $stable(rdata))
        else $error("read data moved without a read");

    // reset clears the read and fetch side but must leave the configuration alone
    a_reset_state: assert property (@(posedge mclk) // reset values
        rst |=> !rvalid && rdata == 8'h00 && pix_kind == HCUR_PIX_SCREEN)
        else $error("read or fetch state not cleared by reset");
    a_base_hold: assert property (@(posedge mclk) // RL4
        &addr_seen_q && !(port.wr && (port.index == `HCUR_IDX_ADDR_LOW
        || port.index == `HCUR_IDX_ADDR_MID || port.index == `HCUR_IDX_ADDR_HIGH))
        |=> $stable(and_base))
        else $error("mask base changed without a write");

    // remaining pixel classes; the column picks the bit, leftmost pixel on bit 7
    a_kind_color0: assert property (@(posedge mclk) disable iff (rst) // RL15
        !and_byte[3'h7 - pix_col[2:0]] && !xor_byte[3'h7 - pix_col[2:0]]
        |=> pix_kind == HCUR_PIX_COLOR0)
        else $error("colour 0 pixel misclassified");
    a_kind_color1: assert property (@(posedge mclk) disable iff (rst) // RL15
        !and_byte[3'h7 - pix_col[2:0]] && xor_byte[3'h7 - pix_col[2:0]]
        |=> pix_kind == HCUR_PIX_COLOR1)
        else $error("colour 1 pixel misclassified");
    a_kind_invert: assert property (@(posedge mclk) disable iff (rst) // RL15
        and_byte[3'h7 - pix_col[2:0]] && xor_byte[3'h7 - pix_col[2:0]]
        |=> pix_kind == HCUR_PIX_INVERT)
        else $error("inverting pixel misclassified");
    a_row_start: assert property (@(posedge mclk) disable iff (rst) // RL12
        &addr_seen_q && pix_col == 6'h00 |=> fetch_and_addr[2:0] == 3'h0)
        else $error("row does not start on a fresh byte");
    a_plane_span: assert property (@(posedge mclk) disable iff (rst) // RL9
        &addr_seen_q |=> fetch_and_addr[26:9] == $past(base_w[26:9])
        && fetch_xor_addr[8:0] == fetch_and_addr[8:0])
        else $error("fetch left its 512-byte plane");

    // main scenarios the bench is expected to reach
    c_write_red:  cover property (@(posedge mclk) port.wr && port.index == `HCUR_IDX_RED);
    c_read_blue:  cover property (@(posedge mclk) port.rd && port.index == `HCUR_IDX_BLUE);
    c_invert_px:  cover property (@(posedge mclk) pix_kind == HCUR_PIX_INVERT);
    c_color1_px:  cover property (@(posedge mclk) pix_kind == HCUR_PIX_COLOR1);
    c_last_pixel: cover property (@(posedge mclk) pix_row == 6'h3f && pix_col == 6'h3f);
endmodule : hcur_regs
`default_nettype wire

// ==== design/hcur_defs.svh ====
// hcur_defs.svh: offsets, field positions and geometry of the cursor block
// assumes: included by bare name from design files only
`ifndef HCUR_DEFS_SVH
`define HCUR_DEFS_SVH

`define HCUR_IDX_RED        8'h2d
`define HCUR_IDX_GREEN      8'h2e
`define HCUR_IDX_BLUE       8'h2f
`define HCUR_IDX_ADDR_LOW   8'h30
`define HCUR_IDX_ADDR_MID   8'h31
`define HCUR_IDX_ADDR_HIGH  8'h32
`define HCUR_ADDR_W         27
`define HCUR_XOR_OFS        27'h0000200
`define HCUR_WIDTH_PX       7'h40
`define HCUR_BYTES_PER_ROW  4'h8
`define HCUR_PLANE_LAST     9'h1ff

`endif

// ==== design/hcur_pkg.sv ====
// hcur_pkg.sv: types shared by the cursor register block and its fetch helper
// assumes: the defs header supplies numeric constants
package hcur_pkg;

    typedef struct packed {
        logic [7:0] red;
        logic [7:0] green;
        logic [7:0] blue;
    } hcur_rgb_t;

    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] index;
        logic [7:0] wdata;
    } hcur_port_t;

    typedef enum logic [1:0] {
        HCUR_PIX_COLOR0,
        HCUR_PIX_COLOR1,
        HCUR_PIX_SCREEN,
        HCUR_PIX_INVERT
    } hcur_pix_t;

endpackage : hcur_pkg

// ==== design/hcur_bitmap_addr.sv ====
// hcur_bitmap_addr.sv: pixel to byte/bit address of the two cursor planes
// assumes: base is 1 KByte aligned, row 0..63, column 0..63
`timescale 1ns/1ps
`default_nettype none
`include "hcur_defs.svh"

module hcur_bitmap_addr
    import hcur_pkg::*;
(
    input  wire logic [26:0] base,
    input  wire logic [5:0]  row,
    input  wire logic [5:0]  col,
    output logic      [26:0] and_addr,
    output logic      [26:0] xor_addr,
    output logic      [2:0]  bit_sel
);
    logic [8:0] byte_ofs;

    // RL9 byte ordering row-major
    assign byte_ofs = {row, col[5:3]};
    assign and_addr = base + {18'h00000, byte_ofs};
    // RL6 xor plane 512 above
    assign xor_addr = base + `HCUR_XOR_OFS + {18'h00000, byte_ofs};
    // RL8 leftmost pixel is bit 7
    assign bit_sel  = 3'h7 - col[2:0];
endmodule : hcur_bitmap_addr
`default_nettype wire

// ==== sim/hcur_regs_tb.sv ====
// hcur_regs_tb.sv: self-checking bench for the cursor colour and mask address registers
// assumes: design package and modules compiled first; inputs change on falling mclk
`timescale 1ns/1ps
`default_nettype none

module hcur_regs_tb;
    import hcur_pkg::*;

    logic        mclk;
    logic        rst;
    hcur_port_t  port;
    logic [5:0]  pix_row;
    logic [5:0]  pix_col;
    logic [7:0]  and_byte;
    logic [7:0]  xor_byte;
    logic [7:0]  rdata;
    logic        rvalid;
    hcur_rgb_t   color1;
    logic [26:0] and_base;
    logic [26:0] fetch_and_addr;
    logic [26:0] fetch_xor_addr;
    hcur_pix_t   pix_kind;
    logic [26:0] base_exp;
    int          fail_count;
    int          check_count;
    int          cycles;

    hcur_regs hcur_regs_inst (
        .mclk(mclk), .rst(rst), .port(port), .pix_row(pix_row), .pix_col(pix_col),
        .and_byte(and_byte), .xor_byte(xor_byte), .rdata(rdata), .rvalid(rvalid),
        .color1(color1), .and_base(and_base), .fetch_and_addr(fetch_and_addr),
        .fetch_xor_addr(fetch_xor_addr), .pix_kind(pix_kind)
    );

    initial begin
        mclk = 1'b0;
        forever #2.5 mclk = ~mclk;
    end

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : tally_and_finish

    // the whole run is well under a hundred cycles, so this only trips on a hang
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 1000) begin
            fail_count++;
            tally_and_finish();
        end
    end

    task automatic chk(input logic [26:0] got, input logic [26:0] exp);
        check_count++;
        if (got !== exp) begin
            fail_count++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // strobes are left high so accesses can run back to back; idle drops them
    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        port = '{wr: 1'b1, rd: 1'b0, index: idx, wdata: d};
        @(negedge mclk);
    endtask : wr

    task automatic rd(input logic [7:0] idx, input logic [7:0] exp);
        port = '{wr: 1'b0, rd: 1'b1, index: idx, wdata: 8'h00};
        @(negedge mclk);
        chk({26'h0, rvalid}, 27'h1);
        chk({19'h0, rdata}, {19'h0, exp});
    endtask : rd

    task automatic idle();
        port = '0;
        @(negedge mclk);
    endtask : idle

    task automatic t_color();
        wr(8'h2d, 8'h55);
        wr(8'h2e, 8'haa);
        wr(8'h2f, 8'h3c);
        wr(8'h2c, 8'hff);
        idle();
        chk({3'h0, color1}, {3'h0, 24'h55aa3c});
        rd(8'h2d, 8'h55);
        rd(8'h2e, 8'haa);
        rd(8'h2f, 8'h3c);
        rd(8'h2c, 8'h00);
        idle();
    endtask : t_color

    // reserved bits go out as zero, the way software has to write them
    task automatic t_addr();
        wr(8'h30, 8'hfc);
        wr(8'h31, 8'ha5);
        wr(8'h32, 8'h07);
        idle();
        base_exp = {3'h7, 8'ha5, 7'h7e, 9'h000};
        chk(and_base, base_exp);
        rd(8'h30, 8'hfc);
        rd(8'h31, 8'ha5);
        rd(8'h32, 8'h07);
        idle();
        chk({26'h0, rvalid}, 27'h0);
        chk({19'h0, rdata}, {19'h0, 8'h07});
    endtask : t_addr

    task automatic px(input logic [5:0] r, input logic [5:0] c, input logic [7:0] a,
                      input logic [7:0] x);
        logic [26:0] ofs;
        logic [2:0]  b;
        hcur_pix_t   k;
        pix_row  = r;
        pix_col  = c;
        and_byte = a;
        xor_byte = x;
        ofs = {18'h0, r, c[5:3]};
        b = 3'h7 - c[2:0];
        k = a[b] ? (x[b] ? HCUR_PIX_INVERT : HCUR_PIX_SCREEN)
                 : (x[b] ? HCUR_PIX_COLOR1 : HCUR_PIX_COLOR0);
        @(negedge mclk);
        chk(fetch_and_addr, base_exp + ofs);
        chk(fetch_xor_addr, base_exp + ofs + 27'h200);
        chk({25'h0, pix_kind}, {25'h0, k});
    endtask : px

    task automatic t_pixel();
        px(6'h00, 6'h00, 8'h80, 8'h00);
        px(6'h00, 6'h09, 8'h00, 8'h40);
        px(6'h05, 6'h14, 8'hf7, 8'hf7);
        px(6'h3f, 6'h3f, 8'h01, 8'h01);
    endtask : t_pixel

    // colour and address registers must ride through a reset untouched
    task automatic t_reset_keep();
        rst = 1'b1;
        @(negedge mclk);
        rst = 1'b0;
        chk({3'h0, color1}, {3'h0, 24'h55aa3c});
        chk(and_base, base_exp);
        chk({25'h0, pix_kind}, {25'h0, HCUR_PIX_SCREEN});
        chk({26'h0, rvalid}, 27'h0);
    endtask : t_reset_keep

    initial begin
        fail_count  = 0;
        check_count = 0;
        cycles      = 0;
        base_exp    = '0;
        port        = '0;
        pix_row     = '0;
        pix_col     = '0;
        and_byte    = '0;
        xor_byte    = '0;
        rst         = 1'b1;
        repeat (16) @(negedge mclk);
        rst = 1'b0;
        t_color();
        t_addr();
        t_pixel();
        t_reset_keep();
        tally_and_finish();
    end
endmodule : hcur_regs_tb

`default_nettype wire
